// ==== core/marg_gate.sv ====
`timescale 1ns/1ps
// Contract
// - One to seven activated permit inputs
// - All-met flag is AND of active permits
// - Blink request at 1 Hz awaiting ack
// - Enable after valid ack, permits held
// - Minimum ack length 100 or 350 ms
// - Too short or over 30 s ignored
// - Any permit drop clears enable immediately
module marg_gate #(
  parameter int unsigned   N_PERMITS     = 7,                    // Activated permits, 1..7
  parameter bit            LONG_MIN      = 1'b0,                 // 0: 100 ms, 1: 350 ms
  parameter longint        MIN_SHORT     = marg_pkg::MIN_SHORT_CYC,  // Short min, cycles
  parameter longint        MIN_LONG      = marg_pkg::MIN_LONG_CYC,   // Long min, cycles
  parameter longint        MAX_PULSE     = marg_pkg::MAX_PULSE_CYC,  // Max pulse, cycles
  parameter longint        HALF_BLINK    = marg_pkg::HALF_BLINK_CYC  // Half blink period
) (
  input  wire logic                 clock_i,           // Logic clock, 125 MHz
  input  wire logic                 rst_i,             // Sync reset, high
  input  wire logic [N_PERMITS-1:0] permit_i,          // Permit pins, async
  input  wire logic                 ack_i,             // Acknowledge button, async
  output logic                      permits_all_met_o, // All permits high
  output logic                      ack_request_blink_o, // Ack request lamp
  output logic                      safe_enable_out_o  // Gated enable
);
  import marg_pkg::*;

  // ****************************************************************
  // Configuration checks
  // ****************************************************************
  // Permit count range
  initial begin
    if (N_PERMITS < 1 || N_PERMITS > MAX_PERM) begin
      $error("permit count out of range");
    end
  end

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [N_PERMITS:0] raw_w;  // Pins bundled for syncing
  logic [N_PERMITS:0] sync_w; // Synchronised pins
  assign raw_w = {ack_i, permit_i};
  marg_sync #(
    .W (N_PERMITS + 1)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     (raw_w),
    .q_o     (sync_w)
  );
  logic permit_and_w; // AND of active permits
  logic ack_w;        // Synchronised ack level
  assign permit_and_w = &sync_w[N_PERMITS-1:0];
  assign ack_w        = sync_w[N_PERMITS];

  // ****************************************************************
  // State
  // ****************************************************************
  localparam logic [CNT_W-1:0] MIN_C  = LONG_MIN ? CNT_W'(MIN_LONG) : CNT_W'(MIN_SHORT);
  localparam logic [CNT_W-1:0] MAX_C  = CNT_W'(MAX_PULSE);
  localparam logic [CNT_W-1:0] HALF_C = CNT_W'(HALF_BLINK);
  typedef struct packed {
    logic             ack_d;   // Ack level one cycle ago
    logic [CNT_W-1:0] hi_cnt;  // Ack high length, saturating
    logic [CNT_W-1:0] bl_cnt;  // Blink half-period counter
    logic             blink;   // Blink phase
    logic             enable;  // Gated enable
  } marg_gate_s;
  marg_gate_s st_r;   // Registered state
  marg_gate_s st_nxt; // Next state
  logic       ack_fall_w; // Ack falling edge
  logic       valid_w;    // Pulse length accepted
  assign ack_fall_w = st_r.ack_d & ~ack_w;
  assign valid_w = (st_r.hi_cnt >= MIN_C) && (st_r.hi_cnt <= MAX_C);

  // Next state logic
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack_d = ack_w;
    if (ack_w) begin
      if (st_r.hi_cnt <= MAX_C) begin
        // Saturate just past the limit; wider counts would only waste flops
        st_nxt.hi_cnt = st_r.hi_cnt + 1'b1;
      end
    end else begin
      st_nxt.hi_cnt = '0;
    end
    if (permit_and_w && ack_fall_w && valid_w) begin
      st_nxt.enable = 1'b1;
    end
    if (!permit_and_w) begin
      st_nxt.enable = 1'b0;
    end
    if (permit_and_w && !st_r.enable) begin
      if (st_r.bl_cnt >= HALF_C - 1'b1) begin
        st_nxt.bl_cnt = '0;
        st_nxt.blink  = ~st_r.blink;
      end else begin
        st_nxt.bl_cnt = st_r.bl_cnt + 1'b1;
      end
    end else begin
      st_nxt.bl_cnt = '0;
      st_nxt.blink  = 1'b0;
    end
  end

  // Register the state
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Enable gated combinationally so a permit drop acts the same cycle
  assign permits_all_met_o   = permit_and_w;
  assign safe_enable_out_o   = st_r.enable & permit_and_w;
  assign ack_request_blink_o = st_r.blink & permit_and_w & ~st_r.enable;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  all_met_and_a: assert property (permits_all_met_o == &sync_w[N_PERMITS-1:0])
    else $error("all-met flag wrong");
  drop_clears_a: assert property (!permits_all_met_o |-> !safe_enable_out_o)
    else $error("enable high with permit low");
  stay_off_a: assert property (!permit_and_w ##1 permit_and_w && !ack_fall_w
                               |-> !safe_enable_out_o)
    else $error("enable returned without ack");
  // Enable rises only on valid ack
  rise_cause_a: assert property ($rose(st_r.enable) |-> $past(ack_fall_w && valid_w))
    else $error("enable rose without valid ack");
  ack_enables_a: assert property (permit_and_w && ack_fall_w && valid_w
                                  |=> st_r.enable)
    else $error("valid ack not taken");
  short_ignored_a: assert property (permit_and_w && !st_r.enable && ack_fall_w
                                    && st_r.hi_cnt < MIN_C |=> !st_r.enable)
    else $error("short pulse accepted");
  long_ignored_a: assert property (permit_and_w && !st_r.enable && ack_fall_w
                                   && st_r.hi_cnt > MAX_C |=> !st_r.enable)
    else $error("long pulse accepted");
  blink_dark_a: assert property (safe_enable_out_o || !permits_all_met_o
                                 |-> !ack_request_blink_o)
    else $error("lamp lit while not awaiting");
  blink_hold_a: assert property (permit_and_w && !st_r.enable && st_r.bl_cnt < HALF_C - 1'b1
                                 |=> st_r.blink == $past(st_r.blink))
    else $error("blink toggled early");
  cnt_clear_a: assert property (!ack_w |=> st_r.hi_cnt == '0)
    else $error("pulse counter not cleared");
  cov_enable_c: cover property ($rose(safe_enable_out_o));
  cov_drop_c:   cover property (safe_enable_out_o ##1 !safe_enable_out_o);
  cov_blink_c:  cover property ($rose(ack_request_blink_o));
  cov_short_c:  cover property (ack_fall_w && !valid_w && permit_and_w);
endmodule : marg_gate

// ==== core/marg_pkg.sv ====
package marg_pkg;
  // ****************************************************************
  // Timing base
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 125_000_000; // Logic clock rate
  localparam int unsigned CLK_PERIOD_NS = 8;           // Logic clock period
  localparam int unsigned MIN_SHORT_MS  = 100;         // Short minimum ack pulse
  localparam int unsigned MIN_LONG_MS   = 350;         // Long minimum ack pulse
  localparam int unsigned MAX_PULSE_S   = 30;          // Longest accepted pulse
  localparam int unsigned BLINK_HZ      = 1;           // Request blink rate
  // Least times round up, longest rounds down
  localparam longint MIN_SHORT_CYC = (longint'(MIN_SHORT_MS) * 1_000_000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam longint MIN_LONG_CYC  = (longint'(MIN_LONG_MS) * 1_000_000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam longint MAX_PULSE_CYC = longint'(MAX_PULSE_S) * CLK_HZ;
  localparam longint HALF_BLINK_CYC = longint'(CLK_HZ) / (2 * BLINK_HZ);
  // ****************************************************************
  // Widths and limits
  // ****************************************************************
  localparam int unsigned CNT_W     = 32; // Pulse and blink counter width
  localparam int unsigned MAX_PERM  = 7;  // Largest permit count
  localparam int unsigned SYNC_W    = 2;  // Synchroniser depth
endpackage : marg_pkg

// ==== core/marg_sync.sv ====
`timescale 1ns/1ps
// ******************************************************************
// Two-flop synchroniser bank
// ******************************************************************
module marg_sync #(
  parameter int unsigned W = 8 // Bits synchronised
) (
  input  wire logic         clock_i, // Logic clock
  input  wire logic         rst_i,   // Sync reset, high
  input  wire logic [W-1:0] d_i,     // Asynchronous inputs
  output logic      [W-1:0] q_o      // Synchronised outputs
);
  import marg_pkg::*;
  // State: first and second stage
  typedef struct packed {
    logic [W-1:0] s1; // First stage, read only by s2
    logic [W-1:0] s2; // Second stage
  } marg_sync_s;
  marg_sync_s st_r;   // Registered state
  marg_sync_s st_nxt; // Next state
  // Shift one stage per clock
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end
  // Register with reset to low
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q_o = st_r.s2;
endmodule : marg_sync

// ==== test/marg_operator.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Operator button and safety sensor model
// ****************************************************************
module marg_operator (
  input  wire logic        clock_i,    // Logic clock
  input  wire logic [2:0]  perm_cmd_i, // Wanted sensor levels
  input  wire logic        go_i,       // Start one button press
  input  wire logic [31:0] len_i,      // Press length in cycles
  output logic      [2:0]  permit_o,   // Sensor lines
  output logic             ack_o       // Button line
);
  int left_r; // Press cycles still to run
  // Lines idle low so nothing is enabled before the bench asks
  initial begin
    permit_o = 3'h0;
    ack_o    = 1'b0;
    left_r   = 0;
  end
  // Lines move just after an edge; button held exactly len_i cycles
  always @(posedge clock_i) begin
    permit_o <= perm_cmd_i;
    left_r   <= go_i ? int'(len_i) : (left_r > 0 ? left_r - 1 : 0);
    ack_o    <= go_i ? (len_i != 32'h0) : (left_r > 1);
  end
endmodule : marg_operator

// ==== test/manual_ack_release_gate_test.sv ====
`timescale 1ns/1ps
module manual_ack_release_gate_test;
  logic        clock_i;  // Logic clock
  logic        rst_i;    // Sync reset
  logic [2:0]  perm_cmd; // Wanted sensor levels
  logic        go;       // Press trigger
  logic [31:0] len;      // Press length
  logic [2:0]  permit;   // Sensor lines
  logic        ack;      // Button line
  logic        all_met;  // All permits high
  logic        blink;    // Request lamp
  logic        enable;   // Gated enable
  int          err_total, n_tests, cyc;
  // ****************************************************************
  // Clock, models and design
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  marg_operator i_marg_operator (.clock_i(clock_i), .perm_cmd_i(perm_cmd), .go_i(go),
    .len_i(len), .permit_o(permit), .ack_o(ack));
  // Shortened counts keep the run brief; short minimum is the default select
  marg_gate #(.N_PERMITS(3), .MIN_SHORT(10), .MIN_LONG(35),
    .MAX_PULSE(200), .HALF_BLINK(8)) i_marg_gate (.clock_i(clock_i), .rst_i(rst_i),
    .permit_i(permit), .ack_i(ack), .permits_all_met_o(all_met),
    .ack_request_blink_o(blink), .safe_enable_out_o(enable));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic set_perm(input logic [2:0] v);
    @(posedge clock_i);
    perm_cmd <= v;
  endtask : set_perm
  // Press, then look well after the synced falling edge is judged
  task automatic t_press(input int l, input logic exp);
    @(posedge clock_i);
    go  <= 1'b1;
    len <= l;
    @(posedge clock_i);
    go <= 1'b0;
    tick(l + 5);
    chk("enable_after_press", enable, exp);
    if (exp) chk("blink_enabled", blink, 1'b0);
  endtask : t_press
  task automatic wrap_up;
    $display("Counts: %0d mismatches in %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_and;
    for (int i = 0; i < 8; i++) begin
      set_perm(i[2:0]);
      tick(4);
      chk("all_met", all_met, &i[2:0]);
      if (i != 7) chk("blink_unmet", blink, 1'b0);
    end
  endtask : t_and
  // Blink restarts low, then toggles exactly every half period
  task automatic t_blink;
    set_perm(3'h0);
    tick(4);
    set_perm(3'h7);
    tick(3);
    chk("blink_start", blink, 1'b0);
    tick(7);
    chk("blink_before_rise", blink, 1'b0);
    tick(1);
    chk("blink_rise", blink, 1'b1);
    tick(7);
    chk("blink_before_fall", blink, 1'b1);
    tick(1);
    chk("blink_fall", blink, 1'b0);
  endtask : t_blink
  // Pin drop reaches the enable after the two sync stages
  task automatic t_drop;
    set_perm(3'h5);
    tick(2);
    chk("enable_before_drop", enable, 1'b1);
    tick(1);
    chk("enable_drop", enable, 1'b0);
    chk("all_met_drop", all_met, 1'b0);
    set_perm(3'h7);
    tick(4);
    chk("enable_rearm", enable, 1'b0);
  endtask : t_drop
  // Press starts while unmet; only the release is judged
  task automatic t_late;
    set_perm(3'h3);
    @(posedge clock_i);
    go  <= 1'b1;
    len <= 32'h28;
    @(posedge clock_i);
    go <= 1'b0;
    tick(10);
    chk("enable_held_ack", enable, 1'b0);
    set_perm(3'h7);
    tick(40);
    chk("enable_late_met", enable, 1'b1);
    chk("blink_late_met", blink, 1'b0);
  endtask : t_late
  // Timeout guard against a hang
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    rst_i = 1'b1;
    perm_cmd = 3'h0;
    go = 1'b0;
    len = 32'h0;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    tick(3);
    chk("enable_reset", enable, 1'b0);
    t_and();
    t_blink();
    t_press(9, 1'b0);
    t_press(201, 1'b0);
    t_press(10, 1'b1);
    t_drop();
    t_press(200, 1'b1);
    set_perm(3'h3);
    t_press(20, 1'b0);
    set_perm(3'h7);
    tick(4);
    chk("enable_unmet_press", enable, 1'b0);
    t_late();
    wrap_up();
  end
endmodule : manual_ack_release_gate_test
